// ---- sdc_pkg.sv ----
// Purpose: shared constants, command and state types for the sdram command decoder
// Assumes: x16 data, two banks, bank select on address bit 11
// Notes:   a burst length of zero stands for full-page bursts
package sdc_pkg;

  localparam int DATA_W        = 16;
  localparam int ADDR_W        = 12;
  localparam int ROW_W         = 11;
  localparam int COL_W         = 8;
  localparam int BANK_BIT      = 11;
  localparam int SCOPE_BIT     = 10;
  localparam int NUM_BANKS     = 2;
  localparam int FIFO_DEPTH    = 16;
  localparam int DEF_BURST_LEN = 4;
  localparam int DEF_CAS_LAT   = 2;
  localparam int DEF_PRE_CYC   = 2;
  localparam int FULL_PAGE     = 0;
  localparam int PRE_CNT_W     = 4;
  localparam int BURST_CNT_W   = 9;

  localparam logic [1:0]        MASK_NONE_N   = 2'h3;
  localparam logic [ADDR_W-1:0] MODE_RST      = 12'h000;
  localparam logic [COL_W-1:0]  COL_STEP      = 8'h01;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ROW_OPEN, CMD_PRECHARGE, CMD_READ,
    CMD_WRITE, CMD_MODE_SET, CMD_REFRESH, CMD_BURST_STOP
  } sdc_cmd_e;

  typedef enum logic [1:0] {BANK_IDLE, BANK_OPEN, BANK_PRECHARGING} sdc_bank_e;

  typedef enum logic [1:0] {PWR_RUN, PWR_SUSPEND, PWR_DOWN, PWR_SELF_REF} sdc_pwr_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdc_cmd_pins_s;

  typedef struct packed {
    logic              bank;
    logic [COL_W-1:0]  col;
    logic [DATA_W-1:0] data;
    logic [1:0]        byte_en;
  } sdc_wr_word_s;

  function automatic sdc_cmd_e sdc_decode(input sdc_cmd_pins_s p);
    sdc_cmd_e c;
    c = CMD_DESELECT;
    if (!p.cs_n) begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h3:    c = CMD_ROW_OPEN;
        3'h2:    c = CMD_PRECHARGE;
        3'h5:    c = CMD_READ;
        3'h4:    c = CMD_WRITE;
        3'h0:    c = CMD_MODE_SET;
        3'h1:    c = CMD_REFRESH;
        3'h6:    c = CMD_BURST_STOP;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

endpackage

// ---- sdc_fifo.sv ----
// Purpose: write-data buffer between the pin side and the array side
// Assumes: one clock, synchronous active-high reset
// Notes:   full and empty come from an occupancy count
`timescale 1ns/10ps
module sdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    wr_ptr_next = push ? step(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = pop ? step(rd_ptr_reg) : rd_ptr_reg;
    cnt_next    = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
    end
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

// ---- sdc_decoder.sv ----
// Purpose: command decoder, bank state, burst engine and byte-mask data path of a two-bank sdram
// Assumes: all pin inputs synchronous to MCLK; read data returned by the array side
// Notes:   data pins are split into in, out and per-byte active-low enables
// Summary of operation
// - chip select and the three strobes, sampled each rising edge, form the command.
// - cs and ras low, cas high: we high opens a row, we low precharges.
// - row open makes the selected bank active and latches the row address.
// - precharge returns the addressed bank to idle once precharge completes.
// - cs low, ras high, cas low starts column access; we low write, high read.
// - a sampled-high byte mask places that byte's data buffers in high impedance.
// - write burst discards any byte whose mask is high on the same edge.
// - read burst blocks an output byte two clocks after its mask is high.
// - high mask governs data lines 15..8, low mask lines 7..0.
// - data in and data out are registered on the rising clock edge.
// - row open, read and write check the bank chosen by the bank select bit; mode set and refresh check both banks.
// - previous clock enable is last edge's level, current is this edge's.
// - enable falling while a bank is active enters clock suspend regardless of command.
// - enable rising leaves clock suspend regardless of chip select and strobes.
// - power-down is refused inside a burst; clock suspend is entered instead.
// - burst stop is accepted for every burst length including full page.
// - chip select high on an edge is a deselect; the command is ignored.
// - read and write take column bits 7..0; bit 10 selects auto-precharge except with full-page bursts.
// - precharge with bit 10 high idles both banks; low only the selected one.
`timescale 1ns/10ps
module sdc_decoder
  import sdc_pkg::*;
#(
  parameter int BURST_LEN = DEF_BURST_LEN,
  parameter int CAS_LAT   = DEF_CAS_LAT,
  parameter int PRE_CYC   = DEF_PRE_CYC
) (
  input  wire logic                          MCLK,
  input  wire logic                          RST,
  input  wire logic                          CKE,
  input  wire sdc_pkg::sdc_cmd_pins_s        CMD_PINS,
  input  wire logic [sdc_pkg::ADDR_W-1:0]    ADDR,
  input  wire logic                          HIGH_BYTE_MASK,
  input  wire logic                          LOW_BYTE_MASK,
  input  wire logic [sdc_pkg::DATA_W-1:0]    DATA_LINES_IN,
  output logic      [sdc_pkg::DATA_W-1:0]    DATA_LINES_OUT,
  output logic      [1:0]                    DATA_LINES_OE_N,
  output logic                               RD_REQ,
  output logic                               RD_BANK,
  output logic      [sdc_pkg::COL_W-1:0]     RD_COL,
  input  wire logic [sdc_pkg::DATA_W-1:0]    RD_DATA,
  output logic                               WR_VALID,
  input  wire logic                          WR_READY,
  output sdc_pkg::sdc_wr_word_s              WR_WORD,
  output logic                               WR_OVERRUN,
  output logic      [1:0]                    BANK_ACTIVE,
  output logic      [1:0][sdc_pkg::ROW_W-1:0] ROW_ADDR,
  output logic      [sdc_pkg::ADDR_W-1:0]    MODE_OPCODE,
  output sdc_pkg::sdc_pwr_e                  PWR_STATE,
  output logic                               REFRESH_PULSE,
  output logic                               BURST_BUSY
);
  import sdc_pkg::*;

  sdc_cmd_e                  cmd;
  logic                      sel;
  logic                      all_idle;
  logic                      any_open;
  logic                      cke_prev_reg;
  sdc_bank_e [1:0]           bank_st_reg;
  sdc_bank_e [1:0]           bank_st_next;
  logic [1:0][ROW_W-1:0]     row_reg;
  logic [1:0][ROW_W-1:0]     row_next;
  logic [1:0][PRE_CNT_W-1:0] pre_cnt_reg;
  logic [1:0][PRE_CNT_W-1:0] pre_cnt_next;
  logic [1:0]                act_reg;
  logic [1:0]                act_next;
  logic                      burst_reg;
  logic                      burst_next;
  logic                      burst_wr_reg;
  logic                      burst_wr_next;
  logic                      burst_bank_reg;
  logic                      burst_bank_next;
  logic                      burst_auto_reg;
  logic                      burst_auto_next;
  logic [BURST_CNT_W-1:0]    burst_left_reg;
  logic [BURST_CNT_W-1:0]    burst_left_next;
  logic [COL_W-1:0]          col_reg;
  logic [COL_W-1:0]          col_next;
  logic [ADDR_W-1:0]         mode_reg;
  logic [ADDR_W-1:0]         mode_next;
  sdc_pwr_e                  pwr_reg;
  sdc_pwr_e                  pwr_next;
  logic                      refresh_reg;
  logic                      refresh_next;
  logic                      overrun_reg;
  logic                      overrun_next;
  logic                      beat_rd;
  logic                      beat_wr;
  logic                      beat_bank;
  logic [COL_W-1:0]          beat_col;
  logic                      fifo_in_valid;
  logic                      fifo_in_ready;
  sdc_wr_word_s              fifo_in;

  assign cmd      = sdc_decode(CMD_PINS);
  // selected bank, and idle/open state across both banks
  assign sel      = ADDR[BANK_BIT];
  assign all_idle = (bank_st_reg[0] == BANK_IDLE) && (bank_st_reg[1] == BANK_IDLE);
  assign any_open = (bank_st_reg[0] == BANK_OPEN) || (bank_st_reg[1] == BANK_OPEN);

  always_comb begin
    bank_st_next    = bank_st_reg;
    row_next        = row_reg;
    pre_cnt_next    = pre_cnt_reg;
    burst_next      = burst_reg;
    burst_wr_next   = burst_wr_reg;
    burst_bank_next = burst_bank_reg;
    burst_auto_next = burst_auto_reg;
    burst_left_next = burst_left_reg;
    col_next        = col_reg;
    mode_next       = mode_reg;
    pwr_next        = pwr_reg;
    refresh_next    = 1'b0;
    overrun_next    = overrun_reg;
    beat_rd         = 1'b0;
    beat_wr         = 1'b0;
    beat_bank       = burst_bank_reg;
    beat_col        = col_reg;
    // commands act only when enable was high last edge
    if (cke_prev_reg) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (bank_st_reg[b] == BANK_PRECHARGING) begin
          if (pre_cnt_reg[b] <= PRE_CNT_W'(1)) begin
            bank_st_next[b] = BANK_IDLE;
          end else begin
            pre_cnt_next[b] = pre_cnt_reg[b] - 1'b1;
          end
        end
      end
      if (burst_reg) begin
        beat_rd  = !burst_wr_reg;
        beat_wr  = burst_wr_reg;
        col_next = col_reg + COL_STEP;
        if (BURST_LEN != FULL_PAGE) begin
          burst_left_next = burst_left_reg - 1'b1;
          if (burst_left_reg == BURST_CNT_W'(1)) begin
            burst_next = 1'b0;
            if (burst_auto_reg) begin
              bank_st_next[burst_bank_reg] = BANK_PRECHARGING;
              pre_cnt_next[burst_bank_reg] = PRE_CNT_W'(PRE_CYC);
            end
          end
        end
      end
      case (cmd)
        // row open versus precharge by write strobe
        // activate selected bank and latch row
        CMD_ROW_OPEN: begin
          if (bank_st_reg[sel] == BANK_IDLE) begin
            bank_st_next[sel] = BANK_OPEN;
            row_next[sel]     = ADDR[ROW_W-1:0];
          end
        end
        // scope bit chooses both banks or one
        CMD_PRECHARGE: begin
          for (int b = 0; b < NUM_BANKS; b++) begin
            if (ADDR[SCOPE_BIT] || (b == int'(sel))) begin
              bank_st_next[b] = BANK_PRECHARGING;
              pre_cnt_next[b] = PRE_CNT_W'(PRE_CYC);
              if (burst_bank_reg == b[0]) begin
                burst_next = 1'b0;
              end
            end
          end
        end
        // column access, write strobe picks direction
        CMD_READ, CMD_WRITE: begin
          if (bank_st_reg[sel] == BANK_OPEN) begin
            beat_rd         = (cmd == CMD_READ);
            beat_wr         = (cmd == CMD_WRITE);
            beat_bank       = sel;
            beat_col        = ADDR[COL_W-1:0];
            col_next        = ADDR[COL_W-1:0] + COL_STEP;
            burst_bank_next = sel;
            burst_wr_next   = (cmd == CMD_WRITE);
            burst_auto_next = ADDR[SCOPE_BIT] && (BURST_LEN != FULL_PAGE);
            burst_left_next = BURST_CNT_W'(BURST_LEN - 1);
            burst_next      = (BURST_LEN != 1);
            if ((BURST_LEN == 1) && ADDR[SCOPE_BIT]) begin
              bank_st_next[sel] = BANK_PRECHARGING;
              pre_cnt_next[sel] = PRE_CNT_W'(PRE_CYC);
            end
          end
        end
        CMD_BURST_STOP: burst_next = 1'b0;
        CMD_MODE_SET: begin
          if (all_idle) begin
            mode_next = ADDR;
          end
        end
        // auto refresh while enable stays high
        CMD_REFRESH: refresh_next = all_idle && CKE;
        default: ;
      endcase
    end
    if (cke_prev_reg && !CKE) begin
      // suspend when a bank is open
      if (any_open || burst_reg) begin
        pwr_next = PWR_SUSPEND;
      end else if ((cmd == CMD_REFRESH) && all_idle) begin
        pwr_next = PWR_SELF_REF;
      end else if ((cmd == CMD_DESELECT) || (cmd == CMD_NOP)) begin
        pwr_next = PWR_DOWN;
      end else begin
        pwr_next = PWR_SUSPEND;
      end
    end else if (!cke_prev_reg && CKE) begin
      // power-down and self refresh exit regardless of chip select and strobes
      pwr_next = PWR_RUN;
    end
    if (fifo_in_valid && !fifo_in_ready) begin
      overrun_next = 1'b1;
    end
    for (int b = 0; b < NUM_BANKS; b++) begin
      act_next[b] = (bank_st_next[b] == BANK_OPEN);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      cke_prev_reg   <= 1'b1;
      bank_st_reg    <= '{default: BANK_IDLE};
      row_reg        <= '0;
      pre_cnt_reg    <= '0;
      act_reg        <= 2'h0;
      burst_reg      <= 1'b0;
      burst_wr_reg   <= 1'b0;
      burst_bank_reg <= 1'b0;
      burst_auto_reg <= 1'b0;
      burst_left_reg <= '0;
      col_reg        <= '0;
      mode_reg       <= MODE_RST;
      pwr_reg        <= PWR_RUN;
      refresh_reg    <= 1'b0;
      overrun_reg    <= 1'b0;
    end else begin
      cke_prev_reg   <= CKE;
      bank_st_reg    <= bank_st_next;
      row_reg        <= row_next;
      pre_cnt_reg    <= pre_cnt_next;
      act_reg        <= act_next;
      burst_reg      <= burst_next;
      burst_wr_reg   <= burst_wr_next;
      burst_bank_reg <= burst_bank_next;
      burst_auto_reg <= burst_auto_next;
      burst_left_reg <= burst_left_next;
      col_reg        <= col_next;
      mode_reg       <= mode_next;
      pwr_reg        <= pwr_next;
      refresh_reg    <= refresh_next;
      overrun_reg    <= overrun_next;
    end
  end

  // masked bytes dropped at the same edge
  // write data taken on the rising edge
  always_comb begin
    fifo_in.bank    = beat_bank;
    fifo_in.col     = beat_col;
    fifo_in.data    = DATA_LINES_IN;
    fifo_in.byte_en = ~{HIGH_BYTE_MASK, LOW_BYTE_MASK};
    fifo_in_valid   = beat_wr && (fifo_in.byte_en != 2'h0);
  end

  sdc_fifo #(
    .WIDTH ($bits(sdc_wr_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (MCLK),
    .rst       (RST),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in),
    .in_ready  (fifo_in_ready),
    .out_valid (WR_VALID),
    .out_data  (WR_WORD),
    .out_ready (WR_READY)
  );

  // read data path
  logic [CAS_LAT-1:0]  rd_pipe_reg;
  logic [CAS_LAT-1:0]  rd_pipe_next;
  logic [1:0]          mask_d1_reg;
  logic [1:0]          mask_d2_reg;
  logic [DATA_W-1:0]   dq_out_reg;
  logic [DATA_W-1:0]   dq_out_next;
  logic [1:0]          oe_n_reg;
  logic [1:0]          oe_n_next;
  logic                rd_req_reg;
  logic                rd_bank_reg;
  logic [COL_W-1:0]    rd_col_reg;

  always_comb begin
    rd_pipe_next = rd_pipe_reg;
    dq_out_next  = dq_out_reg;
    oe_n_next    = oe_n_reg;
    // frozen while the internal clock is suspended
    if (cke_prev_reg) begin
      rd_pipe_next = {rd_pipe_reg[CAS_LAT-2:0], beat_rd};
      oe_n_next    = MASK_NONE_N;
      if (rd_pipe_reg[CAS_LAT-1]) begin
        dq_out_next = RD_DATA;
        // bit 1 high byte, bit 0 low byte
        // masked byte left in high impedance
        oe_n_next   = mask_d2_reg;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rd_pipe_reg <= '0;
      mask_d1_reg <= MASK_NONE_N;
      mask_d2_reg <= MASK_NONE_N;
      dq_out_reg  <= '0;
      oe_n_reg    <= MASK_NONE_N;
      rd_req_reg  <= 1'b0;
      rd_bank_reg <= 1'b0;
      rd_col_reg  <= '0;
    end else begin
      rd_pipe_reg <= rd_pipe_next;
      mask_d1_reg <= {HIGH_BYTE_MASK, LOW_BYTE_MASK};
      mask_d2_reg <= mask_d1_reg;
      dq_out_reg  <= dq_out_next;
      oe_n_reg    <= oe_n_next;
      rd_req_reg  <= beat_rd;
      rd_bank_reg <= beat_bank;
      rd_col_reg  <= beat_col;
    end
  end

  assign DATA_LINES_OUT  = dq_out_reg;
  assign DATA_LINES_OE_N = oe_n_reg;
  assign RD_REQ          = rd_req_reg;
  assign RD_BANK         = rd_bank_reg;
  assign RD_COL          = rd_col_reg;
  assign WR_OVERRUN      = overrun_reg;
  assign BANK_ACTIVE     = act_reg;
  assign ROW_ADDR        = row_reg;
  assign MODE_OPCODE     = mode_reg;
  assign PWR_STATE       = pwr_reg;
  assign REFRESH_PULSE   = refresh_reg;
  assign BURST_BUSY      = burst_reg;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_cke_fall;
    cke_prev_reg && !CKE;
  endsequence
  sequence s_cke_rise;
    !cke_prev_reg && CKE;
  endsequence
  sequence s_open_idle;
    cke_prev_reg && (cmd == CMD_ROW_OPEN) && (bank_st_reg[sel] == BANK_IDLE);
  endsequence

  AST_ROW_OPEN: assert property (s_open_idle |=> BANK_ACTIVE[$past(sel)]
    && (ROW_ADDR[$past(sel)] == $past(ADDR[ROW_W-1:0])))
    else $error("row open did not activate bank");
  AST_DESELECT_IGNORED: assert property (cke_prev_reg && CMD_PINS.cs_n
    |=> $stable(MODE_OPCODE) && !REFRESH_PULSE)
    else $error("deselect changed device state");
  AST_WRITE_MASK: assert property (beat_wr && !(HIGH_BYTE_MASK && LOW_BYTE_MASK)
    |=> WR_VALID || WR_OVERRUN)
    else $error("unmasked write beat not buffered");
  AST_READ_MASK_LAT: assert property (cke_prev_reg && rd_pipe_reg[CAS_LAT-1]
    |=> DATA_LINES_OE_N == $past({HIGH_BYTE_MASK, LOW_BYTE_MASK}, 3))
    else $error("read mask latency wrong");
  AST_SUSPEND_ENTRY: assert property (s_cke_fall ##0 (any_open || burst_reg)
    |=> PWR_STATE == PWR_SUSPEND)
    else $error("clock suspend not entered");
  AST_ENABLE_EXIT: assert property (s_cke_rise |=> PWR_STATE == PWR_RUN)
    else $error("clock suspend not left");
  AST_PRECHARGE_ALL: assert property (cke_prev_reg && (cmd == CMD_PRECHARGE) && ADDR[SCOPE_BIT]
    |=> (BANK_ACTIVE == 2'h0) ##0 (bank_st_reg[0] == BANK_PRECHARGING))
    else $error("precharge all did not close both banks");
  AST_BURST_STOP: assert property (cke_prev_reg && (cmd == CMD_BURST_STOP)
    |=> !BURST_BUSY [*1] ##1 !RD_REQ || BURST_BUSY)
    else $error("burst stop not honoured");
  AST_READ_START: assert property (cke_prev_reg && (cmd == CMD_READ) && (bank_st_reg[sel] == BANK_OPEN)
    |=> RD_REQ && (RD_COL == $past(ADDR[COL_W-1:0])) && (RD_BANK == $past(sel)))
    else $error("read start not requested");
  AST_MODE_SET: assert property (cke_prev_reg && (cmd == CMD_MODE_SET) && all_idle
    |=> MODE_OPCODE == $past(ADDR))
    else $error("mode set not latched");

endmodule

// ---- sdc_array_model.sv ----
// Purpose: array-side partner that returns read data and drains the write buffer
// Assumes: read data is due in the cycle after each read beat request
// Notes:   stall holds the drain off so the buffer can fill
`timescale 1ns/10ps
module sdc_array_model
  import sdc_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       stall,
  input  wire logic                       rd_req,
  input  wire logic [sdc_pkg::COL_W-1:0]  rd_col,
  output logic      [sdc_pkg::DATA_W-1:0] rd_data,
  input  wire logic                       wr_valid,
  output logic                            wr_ready,
  input  wire sdc_pkg::sdc_wr_word_s      wr_word
);
  import sdc_pkg::*;
  sdc_wr_word_s got[$];
  assign wr_ready = !stall;
  always_ff @(posedge clk) begin
    // unrequested cycles never repeat stale data
    rd_data <= rd_req ? {rd_col ^ 8'ha5, rd_col} : ~rd_data;
    if (wr_valid && wr_ready) begin
      got.push_back(wr_word);
    end
  end
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench for the sdram command decoder
// Assumes: full-page bursts, default latencies, inputs driven on falling edges
// Notes:   the bench plays the memory controller on the command pins
`timescale 1ns/10ps
module testbench;
  import sdc_pkg::*;
  logic                  clk, rst, cke, hm, lm, stall;
  logic                  rd_req, rd_bank, wr_valid, wr_ready, ovr, rfr, busy;
  logic [3:0]            pins;
  logic [ADDR_W-1:0]     addr, mode;
  logic [DATA_W-1:0]     din, dout, rd_data;
  logic [1:0]            oe_n, act;
  logic [1:0][ROW_W-1:0] rows;
  logic [COL_W-1:0]      rd_col;
  sdc_wr_word_s          wr_word;
  sdc_pwr_e              pwr;
  int                    failures, checked;

  sdc_decoder #(.BURST_LEN(FULL_PAGE)) uut (
    .MCLK(clk), .RST(rst), .CKE(cke), .CMD_PINS(pins), .ADDR(addr),
    .HIGH_BYTE_MASK(hm), .LOW_BYTE_MASK(lm), .DATA_LINES_IN(din),
    .DATA_LINES_OUT(dout), .DATA_LINES_OE_N(oe_n), .RD_REQ(rd_req),
    .RD_BANK(rd_bank), .RD_COL(rd_col), .RD_DATA(rd_data), .WR_VALID(wr_valid),
    .WR_READY(wr_ready), .WR_WORD(wr_word), .WR_OVERRUN(ovr), .BANK_ACTIVE(act),
    .ROW_ADDR(rows), .MODE_OPCODE(mode), .PWR_STATE(pwr), .REFRESH_PULSE(rfr),
    .BURST_BUSY(busy)
  );

  sdc_array_model arr (
    .clk(clk), .stall(stall), .rd_req(rd_req), .rd_col(rd_col), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word)
  );

  task close_out;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // pins = {cs_n, ras_n, cas_n, we_n}; returns in the cycle after the command edge
  task issue(input logic [3:0] p, input logic [ADDR_W-1:0] a);
    @(negedge clk);
    pins = p;
    addr = a;
    @(negedge clk);
    pins = 4'hf;
  endtask

  task t_row;
    issue(4'hb, 12'h800);
    chk(act, 2'h0);
    issue(4'h3, 12'h9a5);
    chk(act, 2'h2);
    chk(rows[1], 11'h1a5);
  endtask

  task t_read;
    @(negedge clk);
    pins = 4'h5;
    addr = 12'h810;
    hm = 1'b1;
    @(negedge clk);
    pins = 4'hf;
    hm = 1'b0;
    chk({rd_req, rd_bank, rd_col}, {2'h3, 8'h10});
    chk(busy, 1'b1);
    repeat (2) @(negedge clk);
    chk(oe_n, 2'h2);
    chk(dout[7:0], 8'h10);
    @(negedge clk);
    chk(oe_n, 2'h0);
    chk(dout, 16'hb411);
    cke = 1'b0;
    @(negedge clk);
    chk(pwr, PWR_SUSPEND);
    cke = 1'b1;
    @(negedge clk);
    issue(4'h6, 12'h000);
    chk(busy, 1'b0);
  endtask

  task t_write;
    stall = 1'b1;
    @(negedge clk);
    pins = 4'h4;
    addr = 12'h820;
    din = 16'h1000;
    for (int k = 1; k < 20; k++) begin
      @(negedge clk);
      pins = 4'hf;
      din = 16'h1000 + k[15:0];
      lm = (k == 1) || (k == 2);
      hm = (k == 2);
    end
    issue(4'h6, 12'h000);
    chk(ovr, 1'b1);
    stall = 1'b0;
    for (int i = 0; i < 40 && wr_valid; i++) begin
      @(negedge clk);
    end
    chk(wr_valid, 1'b0);
    if (wr_valid) close_out;
    chk(arr.got.size(), 16);
    chk(arr.got[2].col, 8'h23);
    chk(arr.got[0], {1'b1, 8'h20, 16'h1000, 2'h3});
    chk({arr.got[1].col, arr.got[1].byte_en}, {8'h21, 2'h2});
  endtask

  task t_pre;
    issue(4'h3, 12'h123);
    chk(act, 2'h3);
    issue(4'h2, 12'h800);
    issue(4'h3, 12'h8aa);
    chk(act, 2'h1);
    repeat (3) @(negedge clk);
    chk(act, 2'h1);
    issue(4'h3, 12'h8aa);
    chk(act, 2'h3);
    issue(4'h2, 12'h400);
    repeat (3) @(negedge clk);
    chk(act, 2'h0);
  endtask

  task t_power;
    issue(4'h0, 12'h0a7);
    chk(mode, 12'h0a7);
    issue(4'h1, 12'h000);
    chk(rfr, 1'b1);
    cke = 1'b0;
    @(negedge clk);
    chk(pwr, PWR_DOWN);
    cke = 1'b1;
    @(negedge clk);
    chk(pwr, PWR_RUN);
    @(negedge clk);
    pins = 4'h1;
    cke = 1'b0;
    @(negedge clk);
    pins = 4'hf;
    chk(pwr, PWR_SELF_REF);
    chk(rfr, 1'b0);
    cke = 1'b1;
    @(negedge clk);
    chk(pwr, PWR_RUN);
    issue(4'h3, 12'h001);
    cke = 1'b0;
    @(negedge clk);
    chk(pwr, PWR_SUSPEND);
    cke = 1'b1;
    @(negedge clk);
    chk(pwr, PWR_RUN);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    failures = 0;
    checked = 0;
    {rst, cke, hm, lm, stall} = 5'h18;
    pins = 4'hf;
    addr = '0;
    din = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk(oe_n, 2'h3);
    t_row;
    t_read;
    t_write;
    t_pre;
    t_power;
    close_out;
  end
endmodule
